// File: verilog/psup_pkg.sv
// constants and types for the process loop supervisor
package psup_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_LOSS = 8'h04;
  localparam logic [7:0] OFS_SLPFRQ = 8'h08;
  localparam logic [7:0] OFS_SLPDLY = 8'h0c;
  localparam logic [7:0] OFS_FREQ = 8'h10;
  localparam logic [7:0] OFS_TGTLIM = 8'h14;
  localparam logic [7:0] OFS_DISP = 8'h18;
  localparam logic [7:0] OFS_PRECH = 8'h1c;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  localparam logic [7:0] OFS_DISPVAL = 8'h24;
  localparam logic [7:0] OFS_FMIN = 8'h28;
  // control field positions
  localparam int CTL_RUN = 0;
  localparam int CTL_MODE = 1;
  localparam int CTL_PUMP = 5;
  localparam int CTL_REV = 6;
  localparam int CTL_LOSS = 7;
  localparam int CTL_SLEEP = 9;
  localparam int CTL_COMP = 11;
  localparam int CTL_GAIN = 12;
  localparam int CTL_TSRC = 14;
  localparam int CTL_FSRC = 17;
  localparam int CTL_DEC = 20;
  localparam int CTL_UNIT = 23;
  // shared field positions of split registers
  localparam int FLD_LO = 0;
  localparam int FLD_HI = 16;
  localparam int FLD_MID = 8;
  // setting codes
  localparam logic [1:0] LOSS_OFF = 2'h0;
  localparam logic [1:0] LOSS_WARN = 2'h1;
  localparam logic [1:0] LOSS_FAULT = 2'h2;
  localparam logic [1:0] SLP_OFF = 2'h0;
  localparam logic [1:0] SLP_TIMER = 2'h1;
  localparam logic [1:0] SLP_INPUT = 2'h2;
  localparam logic [1:0] GSEL_ONE = 2'h0;
  localparam logic [1:0] GSEL_TWO = 2'h1;
  localparam logic [1:0] GSEL_INPUT = 2'h2;
  localparam logic [2:0] TSRC_CAPPED = 3'h4;
  localparam int MODE_PID_BIT = 0;
  localparam int MODE_UPPER_BIT = 3;
  // frequencies in 0.01 Hz steps
  localparam logic [15:0] FREQ_MAX = 16'h9c40;
  localparam logic [15:0] FINE_LIMIT = 16'h7530;
  localparam logic [15:0] COARSE_STEP = 16'h000a;
  localparam logic [6:0] PCT_FULL = 7'h64;
  localparam logic [3:0] TICKS_PER_SEC = 4'ha;
  // reset values
  localparam logic [6:0] TGT_UPPER_RST = 7'h64;
  localparam logic [13:0] FB_MAX_RST = 14'h2710;
  // tick timing
  localparam real TICK_TIME_S = 0.1;
  localparam real CLK_HZ = 250.0e6;
  localparam int TICK_CYCLES = int'(TICK_TIME_S * CLK_HZ);
  localparam int CNT_W = 12;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_PRECH = 3'b001,
    ST_PID = 3'b010,
    ST_SLEEPW = 3'b011,
    ST_SLEEP = 3'b100,
    ST_FAULT = 3'b101
  } psup_state_e;
endpackage : psup_pkg

// File: verilog/psup_top.sv
// supervisor of the process loop: loss, sleep, gain set, precharge, display
`timescale 1ns/100ps
module psup_top
  import psup_pkg::*;
#(
  parameter int TICK_CNT = TICK_CYCLES
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] wrData,
  input wire logic wrStrobe,
  input wire logic rdStrobe,
  output logic [DATA_W-1:0] rdData,
  input wire logic signed [16:0] pidOut,
  input wire logic [15:0] refFreq,
  input wire logic [15:0] outFreq,
  input wire logic [6:0] fbPct,
  input wire logic [6:0] targetIn,
  input wire logic sleepInput,
  input wire logic gainInput,
  input wire logic rtcTimerOn,
  output logic [15:0] freqCmd,
  output logic motorRun,
  output logic reverseDir,
  output logic faultContact,
  output logic feedbackLossWarn,
  output logic feedbackLossFault,
  output logic pidSelectionError,
  output logic gainSetOne,
  output logic gainSetTwo,
  output logic [6:0] targetOut,
  output logic [13:0] dispFeedback,
  output logic [2:0] dispDecimals,
  output logic [4:0] dispUnit,
  output logic dispPercent
);

  typedef struct packed {
    psup_state_e state;
    logic [24:0] tickCnt;
    logic [CNT_W-1:0] lossCnt;
    logic [CNT_W-1:0] sleepCnt;
    logic [CNT_W-1:0] wakeCnt;
    logic [CNT_W-1:0] prechCnt;
    logic runCmd;
    logic [3:0] ctrlMode;
    logic pumpMode;
    logic revAllow;
    logic [1:0] lossSel;
    logic [1:0] sleepSel;
    logic sleepComp;
    logic [1:0] gainSel;
    logic [2:0] tgtSrc;
    logic [2:0] fbSrc;
    logic [2:0] decWidth;
    logic [4:0] unitSel;
    logic [6:0] lossLvl;
    logic [6:0] lossTime;
    logic [15:0] sleepFreq;
    logic [15:0] wakeFreq;
    logic [11:0] sleepDly;
    logic [11:0] wakeDly;
    logic [15:0] lossFreq;
    logic [15:0] gainLvl;
    logic [6:0] tgtUpper;
    logic [6:0] tgtLower;
    logic [15:0] prechFreq;
    logic [13:0] dispBias;
    logic [13:0] fbMax;
    logic [7:0] prechTime;
    logic [13:0] prechTgt;
    logic [15:0] fMin;
    logic [DATA_W-1:0] rdData;
    logic [15:0] freqCmd;
    logic motorRun;
    logic reverseDir;
    logic faultContact;
    logic lossWarn;
    logic lossFault;
    logic selErr;
    logic gainTwo;
    logic [6:0] targetOut;
    logic [13:0] dispFb;
    logic gainOne;
    logic unitPct;
  } psup_s;

  psup_s st_q;
  psup_s st_d;

  // frequencies above 300 Hz keep only 0.1 Hz resolution
  function automatic logic [15:0] coarsen(input logic [15:0] f);
    logic [15:0] capped;
    capped = (f > FREQ_MAX) ? FREQ_MAX : f;
    coarsen = (capped > FINE_LIMIT) ? capped - (capped % COARSE_STEP) : capped;
  endfunction : coarsen

  // qualification timer: zero on lapse, saturating count on tick
  function automatic logic [CNT_W-1:0] timerNext(input logic [CNT_W-1:0] cnt,
                                                 input logic cond, input logic tick);
    if (!cond) begin
      timerNext = '0;
    end else if (tick && cnt != '1) begin
      timerNext = cnt + 1'b1;
    end else begin
      timerNext = cnt;
    end
  endfunction : timerNext

  logic tick;
  logic pidOn;
  logic sleepOn;
  logic prechOn;
  logic [15:0] sleepThr;
  logic lossCond;
  logic lossHit;
  logic sleepCond;
  logic sleepTimerCond;
  logic sleepHit;
  logic wakeCond;
  logic wakeHit;
  logic prechDone;
  logic [13:0] prechCap;
  logic [11:0] prechLimit;
  logic pidNeg;
  logic [16:0] pidMag;
  logic [15:0] pidFreq;
  logic signed [15:0] fbSpan;
  logic signed [23:0] fbProd;
  logic signed [23:0] fbSum;
  logic [6:0] fbUse;
  logic [6:0] tgtTmp;
  logic wrHit;

  // combinational next state of every register
  always_comb begin
    st_d = st_q;
    st_d.rdData = '0; // read data valid only in the cycle after a read
    // tenth-second tick for all second-based delays
    tick = (st_q.tickCnt == 25'(TICK_CNT - 1));
    st_d.tickCnt = tick ? '0 : st_q.tickCnt + 25'd1;
    wrHit = wrStrobe;

    // software writes; frequency fields are coarsened on entry
    if (wrHit) begin
      case (regAddr)
        OFS_CTRL: begin
          st_d.runCmd = wrData[CTL_RUN];
          st_d.ctrlMode = wrData[CTL_MODE +: 4];
          st_d.pumpMode = wrData[CTL_PUMP];
          st_d.revAllow = wrData[CTL_REV];
          st_d.lossSel = wrData[CTL_LOSS +: 2];
          st_d.sleepSel = wrData[CTL_SLEEP +: 2];
          st_d.sleepComp = wrData[CTL_COMP];
          st_d.gainSel = wrData[CTL_GAIN +: 2];
          st_d.tgtSrc = wrData[CTL_TSRC +: 3];
          st_d.fbSrc = wrData[CTL_FSRC +: 3];
          st_d.decWidth = wrData[CTL_DEC +: 3];
          st_d.unitSel = wrData[CTL_UNIT +: 5];
        end
        OFS_LOSS: begin
          st_d.lossLvl = wrData[FLD_LO +: 7];
          st_d.lossTime = wrData[FLD_MID +: 7];
        end
        OFS_SLPFRQ: begin
          st_d.sleepFreq = coarsen(wrData[FLD_LO +: 16]);
          st_d.wakeFreq = coarsen(wrData[FLD_HI +: 16]);
        end
        OFS_SLPDLY: begin
          st_d.sleepDly = wrData[FLD_LO +: 12];
          st_d.wakeDly = wrData[FLD_HI +: 12];
        end
        OFS_FREQ: begin
          st_d.lossFreq = coarsen(wrData[FLD_LO +: 16]);
          st_d.gainLvl = coarsen(wrData[FLD_HI +: 16]);
        end
        OFS_TGTLIM: begin
          st_d.tgtUpper = wrData[FLD_LO +: 7];
          st_d.tgtLower = wrData[FLD_MID +: 7];
          st_d.prechFreq = coarsen(wrData[FLD_HI +: 16]);
        end
        OFS_DISP: begin
          st_d.dispBias = wrData[FLD_LO +: 14];
          st_d.fbMax = wrData[FLD_HI +: 14];
        end
        OFS_PRECH: begin
          st_d.prechTime = wrData[FLD_LO +: 8];
          st_d.prechTgt = wrData[FLD_HI +: 14];
        end
        OFS_FMIN: st_d.fMin = coarsen(wrData[FLD_LO +: 16]);
        default: ;
      endcase
    end

    // register reads; unmapped addresses answer zero
    if (rdStrobe) begin
      case (regAddr)
        OFS_CTRL: st_d.rdData = {4'h0, st_q.unitSel, st_q.decWidth, st_q.fbSrc,
                                 st_q.tgtSrc, st_q.gainSel, st_q.sleepComp, st_q.sleepSel,
                                 st_q.lossSel, st_q.revAllow, st_q.pumpMode,
                                 st_q.ctrlMode, st_q.runCmd};
        OFS_LOSS: st_d.rdData = {17'h0, st_q.lossTime, 1'b0, st_q.lossLvl};
        OFS_SLPFRQ: st_d.rdData = {st_q.wakeFreq, st_q.sleepFreq};
        OFS_SLPDLY: st_d.rdData = {4'h0, st_q.wakeDly, 4'h0, st_q.sleepDly};
        OFS_FREQ: st_d.rdData = {st_q.gainLvl, st_q.lossFreq};
        OFS_TGTLIM: st_d.rdData = {st_q.prechFreq, 1'b0, st_q.tgtLower, 1'b0, st_q.tgtUpper};
        OFS_DISP: st_d.rdData = {2'h0, st_q.fbMax, 2'h0, st_q.dispBias};
        OFS_PRECH: st_d.rdData = {2'h0, st_q.prechTgt, 8'h0, st_q.prechTime};
        OFS_STATUS: st_d.rdData = {22'h0, st_q.reverseDir, st_q.motorRun, st_q.gainTwo,
                                   st_q.selErr, st_q.lossFault, st_q.lossWarn, 1'b0,
                                   st_q.state};
        OFS_DISPVAL: st_d.rdData = {st_q.freqCmd, 2'h0, st_q.dispFb};
        OFS_FMIN: st_d.rdData = {16'h0, st_q.fMin};
        default: st_d.rdData = '0;
      endcase
    end

    st_d.unitPct = (st_d.unitSel == 5'h00);
    // mode decode
    pidOn = st_q.ctrlMode[MODE_PID_BIT];
    sleepOn = (st_q.sleepSel == SLP_TIMER) ||
              (st_q.sleepSel == SLP_INPUT && sleepInput);
    prechOn = (st_q.prechFreq != '0) && pidOn;
    // bad settings block start and show on the error flag
    st_d.selErr = (st_q.tgtSrc == st_q.fbSrc) ||
                  (st_q.sleepSel != SLP_OFF &&
                   (st_q.revAllow || st_q.ctrlMode[MODE_UPPER_BIT]));

    // feedback display: bias at 0 %, maximum at 100 %
    fbUse = (fbPct > PCT_FULL) ? PCT_FULL : fbPct;
    fbSpan = $signed({2'b00, st_q.fbMax}) - $signed({2'b00, st_q.dispBias});
    fbProd = 24'(fbSpan) * 24'($signed({1'b0, fbUse}));
    fbSum = $signed({10'h0, st_q.dispBias}) + (fbProd / 24'sd100);
    st_d.dispFb = fbSum[23] ? '0 : fbSum[13:0];

    // target clamp; upper wins if limits cross
    tgtTmp = (targetIn < st_q.tgtLower) ? st_q.tgtLower : targetIn;
    st_d.targetOut = (tgtTmp > st_q.tgtUpper) ? st_q.tgtUpper : tgtTmp;

    // gain set choice
    if (st_q.pumpMode && pidOn) begin
      st_d.gainTwo = (outFreq < st_q.gainLvl);
    end else begin
      case (st_q.gainSel)
        GSEL_ONE: st_d.gainTwo = 1'b0;
        GSEL_TWO: st_d.gainTwo = 1'b1;
        GSEL_INPUT: st_d.gainTwo = gainInput;
        default: st_d.gainTwo = rtcTimerOn;
      endcase
    end
    st_d.gainOne = ~st_d.gainTwo;

    // feedback loss qualification in precharge, loop and sleep wait states
    lossCond = (st_q.lossSel != LOSS_OFF) && (fbPct < st_q.lossLvl) &&
               (st_q.state == ST_PRECH || st_q.state == ST_PID ||
                st_q.state == ST_SLEEPW);
    st_d.lossCnt = timerNext(st_q.lossCnt, lossCond, tick);
    lossHit = lossCond && (st_q.lossCnt >= {5'h0, st_q.lossTime});
    st_d.lossWarn = lossHit && (st_q.lossSel == LOSS_WARN);

    // sleep and wake qualification
    sleepThr = (st_q.wakeFreq < st_q.sleepFreq) ? st_q.wakeFreq : st_q.sleepFreq;
    sleepCond = sleepOn && (outFreq < sleepThr);
    sleepTimerCond = (st_q.state == ST_PID && sleepCond) || st_q.state == ST_SLEEPW;
    st_d.sleepCnt = timerNext(st_q.sleepCnt, sleepTimerCond, tick);
    sleepHit = sleepTimerCond && (st_q.sleepCnt >= st_q.sleepDly);
    wakeCond = (st_q.state == ST_SLEEP) && (refFreq > st_q.wakeFreq);
    st_d.wakeCnt = timerNext(st_q.wakeCnt, wakeCond, tick);
    wakeHit = wakeCond && (st_q.wakeCnt >= st_q.wakeDly);

    // precharge end: time or feedback at target
    prechCap = (st_q.tgtSrc == TSRC_CAPPED && st_q.prechTgt > st_q.fbMax) ?
               st_q.fbMax : st_q.prechTgt;
    prechLimit = 12'(st_q.prechTime) * 12'(TICKS_PER_SEC);
    st_d.prechCnt = timerNext(st_q.prechCnt, st_q.state == ST_PRECH, tick);
    prechDone = (st_q.prechCnt >= prechLimit) || (st_d.dispFb >= prechCap);

    // loop output: negative is zero unless reversal allowed
    pidNeg = pidOut[16];
    pidMag = pidNeg ? 17'(-pidOut) : pidOut;
    if (pidNeg && !st_q.revAllow) begin
      pidFreq = '0;
    end else begin
      pidFreq = (pidMag > {1'b0, FREQ_MAX}) ? FREQ_MAX : pidMag[15:0];
    end

    // run sequence
    st_d.state = st_q.state;
    case (st_q.state)
      ST_IDLE: begin
        if (st_q.runCmd && !st_q.selErr) begin
          st_d.state = prechOn ? ST_PRECH : ST_PID;
        end
      end
      ST_PRECH: begin
        if (prechDone) begin
          st_d.state = ST_PID;
        end
      end
      ST_PID: begin
        if (sleepCond && st_q.sleepComp) begin
          st_d.state = ST_SLEEPW;
        end else if (sleepHit) begin
          st_d.state = ST_SLEEP;
        end
      end
      ST_SLEEPW: begin
        if (sleepHit) begin
          st_d.state = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (wakeHit) begin
          st_d.state = ST_PID;
        end
      end
      ST_FAULT: begin
        if (!st_q.runCmd) begin
          st_d.state = ST_IDLE;
        end
      end
      default: st_d.state = ST_IDLE;
    endcase
    if (lossHit && st_q.lossSel == LOSS_FAULT) begin
      st_d.state = ST_FAULT;
    end else if (!st_q.runCmd && st_q.state != ST_FAULT) begin
      st_d.state = ST_IDLE;
    end
    st_d.lossFault = (st_d.state == ST_FAULT);
    st_d.faultContact = (st_d.state == ST_FAULT);

    // drive outputs from the next state; loop inputs are never gated
    st_d.reverseDir = 1'b0;
    case (st_d.state)
      ST_PRECH: begin
        st_d.motorRun = 1'b1;
        st_d.freqCmd = st_q.prechFreq;
      end
      ST_PID: begin
        st_d.motorRun = 1'b1;
        if (st_d.lossWarn) begin
          st_d.freqCmd = st_q.lossFreq;
        end else begin
          st_d.freqCmd = pidFreq;
          st_d.reverseDir = pidNeg && st_q.revAllow;
        end
      end
      ST_SLEEPW: begin
        st_d.motorRun = 1'b1;
        st_d.freqCmd = st_q.fMin;
      end
      ST_SLEEP: begin
        st_d.motorRun = st_q.sleepComp;
        st_d.freqCmd = st_q.sleepComp ? st_q.sleepFreq : '0;
      end
      default: begin
        st_d.motorRun = 1'b0;
        st_d.freqCmd = '0;
      end
    endcase
  end

  // one register stage for all state; synchronous reset
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st_q <= '0;
      st_q.state <= ST_IDLE;
      st_q.tgtUpper <= TGT_UPPER_RST;
      st_q.fbMax <= FB_MAX_RST;
      st_q.gainOne <= 1'b1;
      st_q.unitPct <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign rdData = st_q.rdData;
  assign freqCmd = st_q.freqCmd;
  assign motorRun = st_q.motorRun;
  assign reverseDir = st_q.reverseDir;
  assign faultContact = st_q.faultContact;
  assign feedbackLossWarn = st_q.lossWarn;
  assign feedbackLossFault = st_q.lossFault;
  assign pidSelectionError = st_q.selErr;
  assign gainSetTwo = st_q.gainTwo;
  assign gainSetOne = st_q.gainOne;
  assign targetOut = st_q.targetOut;
  assign dispFeedback = st_q.dispFb;
  assign dispDecimals = st_q.decWidth;
  assign dispUnit = st_q.unitSel;
  assign dispPercent = st_q.unitPct;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  chk_loss_off: assert property (
    st_q.lossSel == LOSS_OFF |=> !feedbackLossWarn && st_q.lossCnt == '0)
    else $error("loss flagged while detection is off");
  chk_loss_warn_run: assert property (
    feedbackLossWarn && st_q.state == ST_PID |-> motorRun && freqCmd == st_q.lossFreq)
    else $error("warning did not keep motor at loss frequency");
  chk_loss_fault_stop: assert property (
    $rose(feedbackLossFault) |-> faultContact && !motorRun && freqCmd == '0)
    else $error("fault did not stop motor and set contact");
  chk_timer_restart: assert property (
    !lossCond ##1 1 |-> st_q.lossCnt == '0)
    else $error("loss timer not restarted after lapse");
  chk_sel_error: assert property (
    (st_q.tgtSrc == st_q.fbSrc) && st_q.state == ST_IDLE && st_q.selErr
    |=> pidSelectionError ##1 (st_q.state == ST_IDLE))
    else $error("selection error not raised for same sources");
  chk_pump_gain: assert property (
    st_q.pumpMode && st_q.ctrlMode[0] && outFreq >= st_q.gainLvl |=> gainSetOne)
    else $error("pump gain set one not chosen at or above level");
  chk_target_clamp: assert property (
    st_q.tgtLower <= st_q.tgtUpper ##1 $stable(st_q.tgtLower) && $stable(st_q.tgtUpper)
    |-> targetOut >= st_q.tgtLower && targetOut <= st_q.tgtUpper)
    else $error("target escaped its limits");
  chk_prech_freq: assert property (
    st_q.state == ST_PRECH |-> motorRun && freqCmd == st_q.prechFreq)
    else $error("precharge not at precharge frequency");
  chk_sleep_stop: assert property (
    st_q.state == ST_SLEEP && !st_q.sleepComp |-> !motorRun && freqCmd == '0)
    else $error("sleep without compensation did not stop motor");
  chk_neg_zero: assert property (
    pidOut[16] && !st_q.revAllow && st_d.state == ST_PID && !st_d.lossWarn
    |=> freqCmd == '0 && !reverseDir)
    else $error("negative loop output not held at zero");
  chk_tick_period: assert property (
    tick |=> st_q.tickCnt == '0 ##1 st_q.tickCnt == 25'd1)
    else $error("tick divider did not restart");
endmodule : psup_top

// File: tb/psup_stage_model.sv
// behavioural output stage and feedback sensor facing the supervisor
`timescale 1ns/100ps
module psup_stage_model
  import psup_pkg::*;
(
  input wire logic ref_clk,
  input wire logic [15:0] freqCmd,
  input wire logic motorRun,
  input wire logic [6:0] fbLevel,
  output logic [15:0] outFreq = 16'h0000,
  output logic [6:0] fbPct
);
  // stage lags the command by one cycle; a stopped motor reads zero, not the old value
  always @(posedge ref_clk) begin
    outFreq <= motorRun ? freqCmd : 16'h0000;
  end
  // sensor passes the process level straight through
  assign fbPct = fbLevel;
endmodule : psup_stage_model

// File: tb/test_psup_top.sv
// self-checking bench for the process loop supervisor
`timescale 1ns/100ps
module test_psup_top
  import psup_pkg::*;
;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic [ADDR_W-1:0] regAddr = '0;
  logic [DATA_W-1:0] wrData = '0;
  logic wrStrobe = 1'b0;
  logic rdStrobe = 1'b0;
  logic [DATA_W-1:0] rdData;
  logic [6:0] targetIn = 7'h00;
  logic [6:0] fbLevel = 7'h00;
  logic gainInput = 1'b0;
  logic rtcTimerOn = 1'b0;
  logic sleepInput = 1'b0;
  logic [15:0] refFreq = 16'h0000;
  logic signed [16:0] pidOut = 17'sh0_0100;
  logic reverseDir, dispPercent;
  logic [2:0] dispDecimals;
  logic [4:0] dispUnit;
  logic [15:0] outFreq, freqCmd;
  logic [6:0] fbPct, targetOut;
  logic [13:0] dispFeedback;
  logic motorRun, faultContact, feedbackLossWarn, feedbackLossFault;
  logic pidSelectionError, gainSetOne, gainSetTwo;
  int errTotal = 0;
  int comparisons = 0;
  // short tick keeps second-based delays to a few cycles
  psup_top #(.TICK_CNT(4)) DUT (.ref_clk(ref_clk), .srst(srst), .regAddr(regAddr),
    .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData),
    .pidOut(pidOut), .refFreq(refFreq), .outFreq(outFreq), .fbPct(fbPct),
    .targetIn(targetIn), .sleepInput(sleepInput), .gainInput(gainInput),
    .rtcTimerOn(rtcTimerOn), .freqCmd(freqCmd), .motorRun(motorRun),
    .reverseDir(reverseDir),
    .faultContact(faultContact), .feedbackLossWarn(feedbackLossWarn),
    .feedbackLossFault(feedbackLossFault), .pidSelectionError(pidSelectionError),
    .gainSetOne(gainSetOne), .gainSetTwo(gainSetTwo), .targetOut(targetOut),
    .dispFeedback(dispFeedback), .dispDecimals(dispDecimals), .dispUnit(dispUnit),
    .dispPercent(dispPercent));
  psup_stage_model stage (.ref_clk(ref_clk), .freqCmd(freqCmd), .motorRun(motorRun),
    .fbLevel(fbLevel), .outFreq(outFreq), .fbPct(fbPct));
  // free-running system clock
  initial begin
    forever #2 ref_clk = ~ref_clk;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      errTotal++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    wrData <= d;
    wrStrobe <= 1'b1;
    @(posedge ref_clk);
    wrStrobe <= 1'b0;
  endtask : reg_write
  // read data stand only in the cycle after the strobe
  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    rdStrobe <= 1'b1;
    @(posedge ref_clk);
    rdStrobe <= 1'b0;
    #1 d = rdData;
  endtask : reg_read
  // run with PID on and distinct target and feedback sources
  function automatic logic [31:0] ctrl(input logic [1:0] lossSel, input logic [1:0] gsel);
    return 32'h0000_0003 | (32'(lossSel) << CTL_LOSS) | (32'(gsel) << CTL_GAIN)
      | (32'h0000_0001 << CTL_TSRC) | (32'h0000_0002 << CTL_FSRC);
  endfunction : ctrl
  task automatic wait_flag(ref logic f, input string what);
    int n;
    for (n = 0; n < 200 && f !== 1'b1; n++) @(posedge ref_clk);
    chk(what, 32'h1, {31'h0, f});
  endtask : wait_flag
  task automatic check_reset_and_bus;
    logic [31:0] d;
    chk("gain one at reset", 32'h1, {31'h0, gainSetOne});
    chk("percent at reset", 32'h1, {31'h0, dispPercent});
    reg_read(OFS_TGTLIM, d);
    chk("target limit reset", 32'h0000_0064, d);
    reg_read(OFS_DISP, d);
    chk("max feedback reset", 32'h2710_0000, d);
    reg_write(8'h30, 32'hffff_ffff);
    reg_read(8'h30, d);
    chk("unmapped read", 32'h0000_0000, d);
  endtask : check_reset_and_bus
  task automatic check_clamp_and_display;
    reg_write(OFS_TGTLIM, 32'h0000_1450);
    reg_write(OFS_DISP, 32'h00c8_000a);
    targetIn <= 7'h5a;
    fbLevel <= 7'h00;
    repeat (3) @(posedge ref_clk);
    chk("target upper clamp", 32'h50, {25'h0, targetOut});
    chk("display at zero", 32'h0a, {18'h0, dispFeedback});
    targetIn <= 7'h0a;
    fbLevel <= 7'h64;
    repeat (3) @(posedge ref_clk);
    chk("target lower clamp", 32'h14, {25'h0, targetOut});
    chk("display at full", 32'hc8, {18'h0, dispFeedback});
    reg_write(OFS_CTRL, 32'h01a0_0000);
    repeat (2) @(posedge ref_clk);
    chk("decimal width", 32'h2, {29'h0, dispDecimals});
    chk("unit code", 32'h3, {27'h0, dispUnit});
    chk("percent off", 32'h0, {31'h0, dispPercent});
  endtask : check_clamp_and_display
  task automatic check_gain_select;
    reg_write(OFS_CTRL, ctrl(LOSS_OFF, GSEL_TWO) & 32'hffff_fffe);
    repeat (2) @(posedge ref_clk);
    chk("gain code one", 32'h1, {31'h0, gainSetTwo});
    reg_write(OFS_CTRL, ctrl(LOSS_OFF, GSEL_INPUT) & 32'hffff_fffe);
    gainInput <= 1'b1;
    repeat (2) @(posedge ref_clk);
    chk("gain by input", 32'h1, {31'h0, gainSetTwo});
    gainInput <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk("gain input idle", 32'h1, {31'h0, gainSetOne});
    reg_write(OFS_CTRL, ctrl(LOSS_OFF, 2'h3) & 32'hffff_fffe);
    rtcTimerOn <= 1'b1;
    repeat (2) @(posedge ref_clk);
    chk("gain by timer", 32'h1, {31'h0, gainSetTwo});
    rtcTimerOn <= 1'b0;
    // pump mode overrides the selector, which asks for set two here
    reg_write(OFS_CTRL, (ctrl(LOSS_OFF, GSEL_TWO) | (32'h1 << CTL_PUMP)) & 32'hffff_fffe);
    repeat (2) @(posedge ref_clk);
    chk("pump at or above level", 32'h1, {31'h0, gainSetOne});
    reg_write(OFS_FREQ, 32'h0100_0000);
    repeat (2) @(posedge ref_clk);
    chk("pump below level", 32'h1, {31'h0, gainSetTwo});
    reg_write(OFS_CTRL, ctrl(LOSS_OFF, GSEL_ONE) & 32'hffff_fffe);
    repeat (2) @(posedge ref_clk);
    chk("gain code zero", 32'h1, {31'h0, gainSetOne});
  endtask : check_gain_select
  task automatic check_selection_error;
    reg_write(OFS_CTRL, 32'h0000_0002 | (32'h1 << CTL_TSRC) | (32'h1 << CTL_FSRC));
    repeat (2) @(posedge ref_clk);
    chk("same source error", 32'h1, {31'h0, pidSelectionError});
    reg_write(OFS_CTRL, ctrl(LOSS_OFF, GSEL_ONE) & 32'hffff_fffe);
    repeat (2) @(posedge ref_clk);
    chk("error clears", 32'h0, {31'h0, pidSelectionError});
    reg_write(OFS_CTRL, (ctrl(LOSS_OFF, GSEL_ONE) & 32'hffff_fffe) | (32'h1 << CTL_SLEEP)
      | (32'h1 << CTL_REV));
    repeat (2) @(posedge ref_clk);
    chk("sleep with reverse", 32'h1, {31'h0, pidSelectionError});
  endtask : check_selection_error
  task automatic check_loss;
    reg_write(OFS_LOSS, 32'h0000_0232);
    reg_write(OFS_FREQ, 32'h0000_0777);
    fbLevel <= 7'h0a;
    reg_write(OFS_CTRL, ctrl(LOSS_WARN, GSEL_ONE));
    wait_flag(feedbackLossWarn, "loss warning");
    chk("loss frequency", 32'h0777, {16'h0, freqCmd});
    chk("runs on warning", 32'h1, {31'h0, motorRun});
    reg_write(OFS_CTRL, ctrl(LOSS_OFF, GSEL_ONE) & 32'hffff_fffe);
    reg_write(OFS_CTRL, ctrl(LOSS_FAULT, GSEL_ONE));
    wait_flag(feedbackLossFault, "loss fault");
    @(posedge ref_clk);
    #1 chk("fault contact", 32'h1, {31'h0, faultContact});
    chk("motor stopped", 32'h0, {31'h0, motorRun});
  endtask : check_loss
  // precharge ends on feedback, then negative loop output with and without reversal
  task automatic check_prech_and_reverse;
    reg_write(OFS_CTRL, ctrl(LOSS_OFF, GSEL_ONE) & 32'hffff_fffe);
    reg_write(OFS_TGTLIM, 32'h0500_1450);
    reg_write(OFS_PRECH, 32'h0096_000a);
    reg_write(OFS_CTRL, ctrl(LOSS_OFF, GSEL_ONE));
    repeat (3) @(posedge ref_clk);
    chk("precharge frequency", 32'h0500, {16'h0, freqCmd});
    fbLevel <= 7'h64;
    repeat (3) @(posedge ref_clk);
    chk("loop after precharge", 32'h0100, {16'h0, freqCmd});
    pidOut <= 17'sh1_fe00;
    repeat (3) @(posedge ref_clk);
    chk("negative held at zero", 32'h0, {16'h0, freqCmd});
    reg_write(OFS_CTRL, ctrl(LOSS_OFF, GSEL_ONE) | (32'h1 << CTL_REV));
    repeat (2) @(posedge ref_clk);
    chk("reverse magnitude", 32'h0200, {16'h0, freqCmd});
    chk("reverse direction", 32'h1, {31'h0, reverseDir});
  endtask : check_prech_and_reverse
  // sleep by timer without compensation, then wake on reference frequency
  task automatic check_sleep_wake;
    pidOut <= 17'sh0_0100;
    reg_write(OFS_SLPFRQ, 32'h0400_0300);
    reg_write(OFS_SLPDLY, 32'h0002_0002);
    reg_write(OFS_CTRL, ctrl(LOSS_OFF, GSEL_ONE) | (32'h1 << CTL_SLEEP));
    repeat (24) @(posedge ref_clk);
    chk("asleep motor stopped", 32'h0, {31'h0, motorRun});
    pidOut <= 17'sh0_0800;
    refFreq <= 16'h0500;
    repeat (24) @(posedge ref_clk);
    chk("awake motor runs", 32'h1, {31'h0, motorRun});
    chk("awake frequency", 32'h0800, {16'h0, freqCmd});
  endtask : check_sleep_wake
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, errTotal);
    if (errTotal == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  // main sequence
  initial begin
    repeat (16) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    #1 check_reset_and_bus();
    check_clamp_and_display();
    check_gain_select();
    check_selection_error();
    check_loss();
    check_prech_and_reverse();
    check_sleep_wake();
    tally_and_finish();
  end
  // watchdog well past the few hundred cycles the scenarios need
  initial begin
    #40000;
    errTotal++;
    tally_and_finish();
  end
endmodule : test_psup_top
